/* File: logic/msl_regs.vh */
/*
 constants for the multilane serial link user-side core.
 assumes it is included by bare name from the logic files.
*/
`ifndef MSL_REGS_VH
`define MSL_REGS_VH
// dataflow modes
`define MSL_FLOW_DUPLEX 2'h0
`define MSL_FLOW_TX_ONLY 2'h1
`define MSL_FLOW_RX_ONLY 2'h2
// simplex back-channel methods
`define MSL_BACK_SIDEBAND 1'h0
`define MSL_BACK_TIMER 1'h1
// rate-pause modes
`define MSL_PAUSE_COMPLETION 1'h0
`define MSL_PAUSE_IMMEDIATE 1'h1
// lane limits
`define MSL_MAX_LANES 16
`define MSL_MIN_LANE_BYTES 2
`define MSL_MAX_LANE_BYTES 4
// character codes placed on the lane side
`define MSL_CHAR_IDLE 8'hbc
`define MSL_CHAR_CC 8'hf7
`define MSL_CHAR_MSG 8'hfe
`define MSL_CHAR_PAUSE 8'hfd
// init timer for the simplex timer method, in ns
`define MSL_INIT_TIME_NS 1000
`define MSL_CLK_PERIOD_NS 4
// width of fields
`define MSL_MSG_LEN_W 3
`define MSL_PAUSE_W 4
`endif

/* File: logic/msl_sync2.v */
/*
 two flip-flop synchroniser for one level.
 assumes a single clock; the first stage is read only by the second.
*/
`timescale 1ns/1ps
module msl_sync2 (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire async_in,
  output wire sync_out
);
  reg meta_reg; // first stage, read only by stage two
  reg sync_reg; // second stage
  // plain double register, reset to a constant
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule

/* File: logic/msl_init_timer.v */
/*
 simplex transmitter init sequencer: advances on sideband or timer.
 assumes sideband inputs are already synchronised.
*/
`timescale 1ns/1ps
`include "msl_regs.vh"
module msl_init_timer #(
  parameter INIT_CYCLES = 250
) (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire use_timer_in,
  input wire sideband_aligned_in,
  input wire sideband_bonded_in,
  input wire sideband_verified_in,
  output wire up_out,
  output wire [1:0] state_out
);
  localparam ST_ALIGN = 2'h0;
  localparam ST_BOND = 2'h1;
  localparam ST_VERIFY = 2'h2;
  localparam ST_READY = 2'h3;
  reg [1:0] state_reg; // init phase
  reg [1:0] state_next;
  reg [15:0] cnt_reg; // time spent in the phase
  reg [15:0] cnt_next;
  wire tick;
  assign tick = (cnt_reg == INIT_CYCLES[15:0]);
  // phase advance: timer or the matching sideband
  always @* begin
    state_next = state_reg;
    cnt_next = tick ? 16'h0000 : cnt_reg + 16'h0001;
    case (state_reg)
      ST_ALIGN: begin
        if (use_timer_in ? tick : sideband_aligned_in)
          state_next = ST_BOND;
      end
      ST_BOND: begin
        if (use_timer_in ? tick : sideband_bonded_in)
          state_next = ST_VERIFY;
      end
      ST_VERIFY: begin
        if (use_timer_in ? tick : sideband_verified_in)
          state_next = ST_READY;
      end
      ST_READY: begin
        cnt_next = 16'h0000; // counter parks once up
      end
      default: begin
        state_next = ST_ALIGN;
      end
    endcase
    if (state_next != state_reg)
      cnt_next = 16'h0000;
  end
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_ALIGN;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end
  assign up_out = (state_reg == ST_READY);
  assign state_out = state_reg;
endmodule

/* File: logic/msl_user_side.v */
/*
 user-facing side of a multilane 8b/10b serial link: transmit and receive
 user data, short priority messages, rate-pause messages and clock
 compensation, plus the control and status pins.
 assumes lane coding and bonding sit below, on the same clock; lane-side
 data here is one control bit per byte plus data.
*/
// Notes on behaviour
// - one to sixteen lanes bonded per channel
// - each lane carries two or four bytes
// - duplex, transmit-only or receive-only build
// - simplex init advances on sideband or timer
// - receiver may throttle partner via rate pause
// - completion mode: idles after current frame ends
// - immediate mode: idles at once, even mid-frame
// - framing port is stream style, strips control characters
// - streaming: one endless frame, data with valid
// - data port width follows lanes and lane bytes
// - simplex builds keep every port; the unused direction stays idle except the receive last flags, driven from lane_rx_last_in
// - message send: request, acknowledge, three-bit length
// - after message acknowledge, data ready drops
// - received messages leave on their own stream port
// - rate pause: request, acknowledge, four-bit idle count
// - clock-comp request halts data, sends comp sequences
// - clock-comp warning keeps messages off comp sequences
// - comp interface only when transmitting, managed outside
// - control pins and channel status outputs present
// - idle characters whenever no user data, message, pause or comp character is sent
`timescale 1ns/1ps
`include "msl_regs.vh"
module msl_user_side #(
  parameter LANES = 1,
  parameter LANE_BYTES = 2,
  parameter FLOW_MODE = `MSL_FLOW_DUPLEX,
  parameter BACK_CHANNEL = `MSL_BACK_SIDEBAND,
  parameter PAUSE_MODE = `MSL_PAUSE_COMPLETION,
  parameter FRAMING = 1,
  parameter INIT_CYCLES = (`MSL_INIT_TIME_NS + `MSL_CLK_PERIOD_NS - 1) /
    `MSL_CLK_PERIOD_NS,
  parameter DW = LANES * LANE_BYTES * 8,
  parameter BW = LANES * LANE_BYTES
) (
  input wire core_clk_in,
  input wire sys_rst_in,
  // transmit user port
  input wire [DW-1:0] tx_data_in,
  input wire tx_valid_in,
  input wire tx_last_in,
  output wire tx_ready_out,
  // short priority messaging, transmit
  input wire msg_req_in,
  input wire [`MSL_MSG_LEN_W-1:0] msg_len_in,
  output wire msg_ack_out,
  // rate pause messaging, transmit
  input wire pause_req_in,
  input wire [`MSL_PAUSE_W-1:0] pause_count_in,
  output wire pause_ack_out,
  // clock compensation
  input wire clock_comp_request_in,
  input wire clock_comp_warning_in,
  // receive user port
  output wire [DW-1:0] rx_data_out,
  output wire rx_valid_out,
  output wire rx_last_out,
  output wire [DW-1:0] rx_msg_data_out,
  output wire rx_msg_valid_out,
  output wire rx_msg_last_out,
  // lane side
  output wire [DW-1:0] lane_tx_data_out,
  output wire [BW-1:0] lane_tx_ctrl_out,
  input wire [DW-1:0] lane_rx_data_in,
  input wire [BW-1:0] lane_rx_ctrl_in,
  input wire lane_rx_pause_in,
  input wire [`MSL_PAUSE_W-1:0] lane_rx_pause_count_in,
  input wire lane_rx_msg_in,
  input wire lane_rx_last_in,
  // control and status pins
  input wire lane_up_in,
  input wire sb_aligned_in,
  input wire sb_bonded_in,
  input wire sb_verified_in,
  input wire loopback_in,
  input wire bond_enable_in,
  input wire clk_correct_in,
  input wire power_down_in,
  output wire loopback_out,
  output wire bond_enable_out,
  output wire clk_correct_out,
  output wire power_down_out,
  output wire channel_up_out,
  output wire [1:0] init_state_out,
  output wire hard_error_out
);
  localparam HAS_TX = (FLOW_MODE != `MSL_FLOW_RX_ONLY);
  localparam HAS_RX = (FLOW_MODE != `MSL_FLOW_TX_ONLY);
  // transmit states
  localparam TX_IDLE = 2'h0;
  localparam TX_FRAME = 2'h1;
  localparam TX_MSG = 2'h2;
  localparam TX_PAUSE = 2'h3;

  // fill every byte with one character
  function [DW-1:0] fill_char;
    input [7:0] ch;
    integer i;
    begin
      fill_char = {DW{1'b0}};
      for (i = 0; i < BW; i = i + 1)
        fill_char[i*8 +: 8] = ch;
    end
  endfunction

  // clear control bytes so they never reach the user
  function [DW-1:0] strip_ctrl;
    input [DW-1:0] d;
    input [BW-1:0] c;
    integer i;
    begin
      strip_ctrl = d;
      for (i = 0; i < BW; i = i + 1)
        if (c[i])
          strip_ctrl[i*8 +: 8] = 8'h00;
    end
  endfunction

  wire lane_up_s; // synchronised pin inputs
  wire sb_al_s;
  wire sb_bo_s;
  wire sb_ve_s;
  wire cc_req_s;
  wire cc_warn_s;
  wire timer_up;
  msl_sync2 u_sync_up (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .async_in(lane_up_in), .sync_out(lane_up_s));
  msl_sync2 u_sync_al (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .async_in(sb_aligned_in), .sync_out(sb_al_s));
  msl_sync2 u_sync_bo (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .async_in(sb_bonded_in), .sync_out(sb_bo_s));
  msl_sync2 u_sync_ve (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .async_in(sb_verified_in), .sync_out(sb_ve_s));
  // comp pins driven by a management module, maybe on another clock
  msl_sync2 u_sync_cc (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .async_in(clock_comp_request_in), .sync_out(cc_req_s));
  msl_sync2 u_sync_cw (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .async_in(clock_comp_warning_in), .sync_out(cc_warn_s));

  // simplex transmit init; duplex uses the lane-up pin directly
  msl_init_timer #(.INIT_CYCLES(INIT_CYCLES)) u_init (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .use_timer_in(BACK_CHANNEL == `MSL_BACK_TIMER),
    .sideband_aligned_in(sb_al_s & lane_up_s),
    .sideband_bonded_in(sb_bo_s),
    .sideband_verified_in(sb_ve_s),
    .up_out(timer_up),
    .state_out(init_state_out)
  );

  wire chan_up; // channel ready for user traffic
  assign chan_up = (FLOW_MODE == `MSL_FLOW_TX_ONLY) ? timer_up : lane_up_s;

  reg [1:0] tx_state_reg; // transmit state
  reg [1:0] tx_state_next;
  reg [`MSL_MSG_LEN_W:0] msg_left_reg; // message words still to send
  reg [`MSL_MSG_LEN_W:0] msg_left_next;
  reg [`MSL_PAUSE_W-1:0] idle_left_reg; // forced idle cycles left
  reg [`MSL_PAUSE_W-1:0] idle_left_next;
  reg pause_pend_reg; // pause waiting for frame end
  reg pause_pend_next;
  reg [DW-1:0] tx_lane_reg; // lane data, from flops
  reg [DW-1:0] tx_lane_next;
  reg [BW-1:0] tx_ctrl_reg;
  reg [BW-1:0] tx_ctrl_next;
  reg msg_ack_reg; // one-cycle acknowledge pulses
  reg msg_ack_next;
  reg pause_ack_reg;
  reg pause_ack_next;
  reg in_frame_reg; // user frame open on the wire
  reg in_frame_next;

  wire pause_in; // partner asks us to hold off
  assign pause_in = HAS_TX && HAS_RX && lane_rx_pause_in;
  wire cc_now;
  assign cc_now = HAS_TX && cc_req_s;
  wire data_ok; // user data may move this cycle
  assign data_ok = chan_up && !cc_now && (tx_state_reg != TX_PAUSE) &&
    (tx_state_reg != TX_MSG) && !msg_ack_reg;

  // transmit scheduler: comp beats pause beats message beats data
  always @* begin
    tx_state_next = tx_state_reg;
    msg_left_next = msg_left_reg;
    idle_left_next = idle_left_reg;
    pause_pend_next = pause_pend_reg;
    in_frame_next = in_frame_reg;
    msg_ack_next = 1'b0;
    pause_ack_next = 1'b0;
    tx_lane_next = fill_char(`MSL_CHAR_IDLE);
    tx_ctrl_next = {BW{1'b1}};
    if (pause_in)
      pause_pend_next = 1'b1;
    if (!HAS_TX || !chan_up) begin
      tx_state_next = TX_IDLE;
      in_frame_next = 1'b0;
      pause_pend_next = 1'b0;
    end else if (cc_now) begin
      tx_lane_next = fill_char(`MSL_CHAR_CC);
    end else begin
      case (tx_state_reg)
        TX_IDLE, TX_FRAME: begin
          if (pause_pend_reg || pause_in) begin
            if (PAUSE_MODE == `MSL_PAUSE_IMMEDIATE || !in_frame_reg) begin
              tx_state_next = TX_PAUSE;
              idle_left_next = lane_rx_pause_count_in;
              pause_pend_next = 1'b0;
            end
          end
          if (tx_state_next != TX_PAUSE) begin
            if (msg_req_in && !cc_warn_s && !msg_ack_reg) begin
              msg_ack_next = 1'b1;
              tx_state_next = TX_MSG;
              msg_left_next = {1'b0, msg_len_in} + 4'h1;
              tx_lane_next = fill_char(`MSL_CHAR_MSG);
            end else if (pause_req_in && HAS_RX && !pause_ack_reg) begin
              pause_ack_next = 1'b1;
              tx_lane_next = fill_char(`MSL_CHAR_PAUSE);
              tx_lane_next[`MSL_PAUSE_W-1:0] = pause_count_in;
            end else if (tx_valid_in && data_ok) begin
              tx_lane_next = tx_data_in;
              tx_ctrl_next = {BW{1'b0}};
              in_frame_next = FRAMING ? !tx_last_in : 1'b1;
              tx_state_next = TX_FRAME;
            end
          end
        end
        TX_MSG: begin
          // message words ride the ordinary data port
          if (tx_valid_in) begin
            tx_lane_next = tx_data_in;
            tx_ctrl_next = {BW{1'b0}};
            msg_left_next = msg_left_reg - 4'h1;
            if (msg_left_reg == 4'h1)
              tx_state_next = in_frame_reg ? TX_FRAME : TX_IDLE;
          end
        end
        TX_PAUSE: begin
          if (idle_left_reg == 4'h0)
            tx_state_next = in_frame_reg ? TX_FRAME : TX_IDLE;
          else
            idle_left_next = idle_left_reg - 4'h1;
        end
        default: begin
          tx_state_next = TX_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_state_reg <= TX_IDLE;
      msg_left_reg <= 4'h0;
      idle_left_reg <= 4'h0;
      pause_pend_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      msg_ack_reg <= 1'b0;
      pause_ack_reg <= 1'b0;
      tx_lane_reg <= {DW{1'b0}};
      tx_ctrl_reg <= {BW{1'b1}};
    end else begin
      tx_state_reg <= tx_state_next;
      msg_left_reg <= msg_left_next;
      idle_left_reg <= idle_left_next;
      pause_pend_reg <= pause_pend_next;
      in_frame_reg <= in_frame_next;
      msg_ack_reg <= msg_ack_next;
      pause_ack_reg <= pause_ack_next;
      tx_lane_reg <= tx_lane_next;
      tx_ctrl_reg <= tx_ctrl_next;
    end
  end

  // ready is combinational; it falls in the cycle that decides an acknowledge, and in the
  // cycle that enters a pause, else the word offered there would be lost
  assign tx_ready_out = HAS_TX && data_ok && !msg_ack_next &&
    !pause_ack_next && (tx_state_next != TX_PAUSE);
  assign msg_ack_out = msg_ack_reg;
  assign pause_ack_out = pause_ack_reg;
  assign lane_tx_data_out = tx_lane_reg;
  assign lane_tx_ctrl_out = tx_ctrl_reg;

  reg [DW-1:0] rx_data_reg; // receive data, stripped
  reg rx_valid_reg;
  reg rx_last_reg;
  reg [DW-1:0] rx_msg_reg; // received messages, own port
  reg rx_msg_valid_reg;
  reg rx_msg_last_reg;
  wire rx_has_data;
  assign rx_has_data = HAS_RX && lane_up_s && (lane_rx_ctrl_in != {BW{1'b1}});

  // receive path: control-only words are dropped, control bytes cleared
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_data_reg <= {DW{1'b0}};
      rx_valid_reg <= 1'b0;
      rx_last_reg <= 1'b0;
      rx_msg_reg <= {DW{1'b0}};
      rx_msg_valid_reg <= 1'b0;
      rx_msg_last_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_has_data && !lane_rx_msg_in;
      rx_msg_valid_reg <= rx_has_data && lane_rx_msg_in;
      rx_last_reg <= FRAMING && lane_rx_last_in && !lane_rx_msg_in;
      rx_msg_last_reg <= lane_rx_last_in && lane_rx_msg_in;
      if (rx_has_data && !lane_rx_msg_in)
        rx_data_reg <= strip_ctrl(lane_rx_data_in, lane_rx_ctrl_in);
      if (rx_has_data && lane_rx_msg_in)
        rx_msg_reg <= strip_ctrl(lane_rx_data_in, lane_rx_ctrl_in);
    end
  end
  assign rx_data_out = rx_data_reg;
  assign rx_valid_out = rx_valid_reg;
  assign rx_last_out = rx_last_reg;
  assign rx_msg_data_out = rx_msg_reg;
  assign rx_msg_valid_out = rx_msg_valid_reg;
  assign rx_msg_last_out = rx_msg_last_reg;

  reg [3:0] ctrl_reg; // control pins, registered toward the lanes
  reg err_reg;
  // controls pass through; an error flags channel loss while the transmitter is not idle
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= 4'h0;
      err_reg <= 1'b0;
    end else begin
      ctrl_reg <= {loopback_in, bond_enable_in, clk_correct_in,
        power_down_in};
      err_reg <= tx_state_reg != TX_IDLE && !chan_up;
    end
  end
  assign loopback_out = ctrl_reg[3];
  assign bond_enable_out = ctrl_reg[2];
  assign clk_correct_out = ctrl_reg[1];
  assign power_down_out = ctrl_reg[0];
  assign channel_up_out = chan_up;
  assign hard_error_out = err_reg;
endmodule

/* File: testbench/msl_user_properties.sv */
/*
 checker for the link user side: port relations over time.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "msl_regs.vh"
module msl_user_chk #(
  parameter DW = 16,
  parameter BW = 2
) (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire [DW-1:0] tx_data_in,
  input wire tx_valid_in,
  input wire tx_ready_out,
  input wire msg_req_in,
  input wire msg_ack_out,
  input wire pause_req_in,
  input wire pause_ack_out,
  input wire clock_comp_request_in,
  input wire clock_comp_warning_in,
  input wire [DW-1:0] rx_data_out,
  input wire rx_valid_out,
  input wire rx_msg_valid_out,
  input wire [DW-1:0] lane_tx_data_out,
  input wire [BW-1:0] lane_tx_ctrl_out,
  input wire [BW-1:0] lane_rx_ctrl_in,
  input wire [DW-1:0] lane_rx_data_in,
  input wire lane_rx_msg_in,
  input wire loopback_in,
  input wire power_down_in,
  input wire loopback_out,
  input wire power_down_out,
  input wire channel_up_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // a whole data word arrives on a live channel
  wire rx_word = (lane_rx_ctrl_in == {BW{1'b0}}) && channel_up_out;
  property p_pins;
    !$past(sys_rst_in) |-> loopback_out == $past(loopback_in) &&
      power_down_out == $past(power_down_in);
  endproperty
  a_pins: assert property (p_pins) else $error("pin lag wrong");
  property p_down;
    !channel_up_out |-> !tx_ready_out;
  endproperty
  a_down: assert property (p_down) else $error("ready while down");
  property p_tx;
    tx_valid_in && tx_ready_out |=> lane_tx_ctrl_out == {BW{1'b0}} &&
      lane_tx_data_out == $past(tx_data_in);
  endproperty
  a_tx: assert property (p_tx) else $error("lane word wrong");
  property p_cc_stall;
    clock_comp_request_in [*4] |-> !tx_ready_out;
  endproperty
  a_cc_stall: assert property (p_cc_stall) else $error("no stall");
  property p_cc_char;
    clock_comp_request_in [*5] |-> lane_tx_ctrl_out == {BW{1'b1}} &&
      lane_tx_data_out == {BW{`MSL_CHAR_CC}};
  endproperty
  a_cc_char: assert property (p_cc_char) else $error("no comp");
  property p_msg_ack;
    msg_ack_out |-> ($past(msg_req_in) && !tx_ready_out) ##1 !msg_ack_out;
  endproperty
  a_msg_ack: assert property (p_msg_ack) else $error("bad ack");
  property p_warn;
    clock_comp_warning_in [*4] |-> !msg_ack_out;
  endproperty
  a_warn: assert property (p_warn) else $error("ack in warning");
  property p_pause_ack;
    pause_ack_out |-> $past(pause_req_in) ##1 !pause_ack_out;
  endproperty
  a_pause_ack: assert property (p_pause_ack) else $error("bad ack");
  property p_rx_data;
    rx_word && !lane_rx_msg_in |=> rx_valid_out && !rx_msg_valid_out &&
      rx_data_out == $past(lane_rx_data_in);
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx word");
  property p_rx_strip;
    lane_rx_ctrl_in == {BW{1'b1}} |=> !rx_valid_out && !rx_msg_valid_out;
  endproperty
  a_rx_strip: assert property (p_rx_strip) else $error("idle seen");
  property p_rx_msg;
    rx_word && lane_rx_msg_in |=> rx_msg_valid_out && !rx_valid_out;
  endproperty
  a_rx_msg: assert property (p_rx_msg) else $error("rx msg");
  c_msg: cover property (msg_ack_out);
  c_pause: cover property (pause_ack_out);
  c_comp: cover property (clock_comp_request_in [*5]);
  c_rx_msg: cover property (rx_msg_valid_out);
endmodule
bind msl_user_side msl_user_chk #(.DW(DW), .BW(BW)) u_chk (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
  .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
  .tx_ready_out(tx_ready_out), .msg_req_in(msg_req_in),
  .msg_ack_out(msg_ack_out), .pause_req_in(pause_req_in),
  .pause_ack_out(pause_ack_out),
  .clock_comp_request_in(clock_comp_request_in),
  .clock_comp_warning_in(clock_comp_warning_in),
  .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
  .rx_msg_valid_out(rx_msg_valid_out),
  .lane_tx_data_out(lane_tx_data_out), .lane_tx_ctrl_out(lane_tx_ctrl_out),
  .lane_rx_ctrl_in(lane_rx_ctrl_in), .lane_rx_data_in(lane_rx_data_in),
  .lane_rx_msg_in(lane_rx_msg_in), .loopback_in(loopback_in),
  .power_down_in(power_down_in), .loopback_out(loopback_out),
  .power_down_out(power_down_out), .channel_up_out(channel_up_out)
);

/* File: testbench/msl_far_model.sv */
/*
 far-end link model: sources lane words toward the receive side.
 assumes the core clock; idles fill every cycle without a word.
*/
`timescale 1ns/1ps
`include "msl_regs.vh"
module msl_far_model #(
  parameter DW = 16,
  parameter BW = 2
) (
  input wire core_clk_in,
  input wire send_in, // a word goes out this cycle
  input wire msg_in, // the word belongs to a message
  input wire last_in,
  input wire [DW-1:0] word_in,
  input wire pause_in,
  input wire [3:0] pause_count_in,
  output reg [DW-1:0] lane_rx_data_out,
  output reg [BW-1:0] lane_rx_ctrl_out,
  output reg lane_rx_msg_out,
  output reg lane_rx_last_out,
  output reg lane_rx_pause_out,
  output reg [3:0] lane_rx_pause_count_out
);
  // one registered word a cycle; gaps are slow answers
  always @(posedge core_clk_in) begin
    if (send_in) begin
      lane_rx_data_out <= word_in;
      lane_rx_ctrl_out <= {BW{1'b0}};
    end else begin
      // keep the link alive between words
      lane_rx_data_out <= {BW{`MSL_CHAR_IDLE}};
      lane_rx_ctrl_out <= {BW{1'b1}};
    end
    lane_rx_msg_out <= send_in & msg_in;
    lane_rx_last_out <= send_in & last_in;
    lane_rx_pause_out <= pause_in;
    lane_rx_pause_count_out <= pause_count_in;
  end
endmodule

/* File: testbench/tb.sv */
/*
 self-checking bench for the link user side with a far-end model.
 assumes a 250 MHz clock and one lane of two bytes.
*/
`timescale 1ns/1ps
`include "msl_regs.vh"
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] txd = 16'h0;
  reg txv = 1'b0, txl = 1'b0, mreq = 1'b0, preq = 1'b0;
  reg [2:0] mlen = 3'h0;
  reg [3:0] pcnt = 4'h0, pin = 4'h0, fc = 4'h0;
  reg ccr = 1'b0, ccw = 1'b0, lup = 1'b0; // comp pins low by default
  reg [2:0] sbx = 3'h0; // sideband levels: verified, bonded, aligned
  reg fs = 1'b0, fm = 1'b0, fl = 1'b0, fp = 1'b0; // far-end stimulus
  reg [15:0] fw = 16'h0;
  reg chk_idle = 1'b0, chk_rx = 1'b0; // monitor enables
  reg acc_q = 1'b0; // word taken at the last edge
  reg [15:0] txd_q, rd_q;
  reg [1:0] rk_q, rl_q; // kind and last flags of last lane word: msg, data
  reg [31:0] seed = 32'h82f2;
  integer miscompares, n_checks, i, w, n, cyc = 0;
  wire rdy, mack, pack, rxv, rxl, rmv, rml, cup, herr, lrm, lrl, lrp;
  wire [15:0] rxd, rmd, ltd, lrd;
  wire [1:0] ltc, lrc, ist;
  wire [3:0] pout, lrpc;
  msl_user_side #(.LANES(1), .LANE_BYTES(2), .INIT_CYCLES(4)) dut (
    .core_clk_in(clk), .sys_rst_in(rst), .tx_data_in(txd),
    .tx_valid_in(txv), .tx_last_in(txl), .tx_ready_out(rdy),
    .msg_req_in(mreq), .msg_len_in(mlen), .msg_ack_out(mack),
    .pause_req_in(preq), .pause_count_in(pcnt), .pause_ack_out(pack),
    .clock_comp_request_in(ccr), .clock_comp_warning_in(ccw),
    .rx_data_out(rxd), .rx_valid_out(rxv), .rx_last_out(rxl),
    .rx_msg_data_out(rmd), .rx_msg_valid_out(rmv), .rx_msg_last_out(rml),
    .lane_tx_data_out(ltd), .lane_tx_ctrl_out(ltc),
    .lane_rx_data_in(lrd), .lane_rx_ctrl_in(lrc), .lane_rx_pause_in(lrp),
    .lane_rx_pause_count_in(lrpc), .lane_rx_msg_in(lrm),
    .lane_rx_last_in(lrl), .lane_up_in(lup), .sb_aligned_in(sbx[0]),
    .sb_bonded_in(sbx[1]), .sb_verified_in(sbx[2]), .loopback_in(pin[3]),
    .bond_enable_in(pin[2]), .clk_correct_in(pin[1]),
    .power_down_in(pin[0]), .loopback_out(pout[3]),
    .bond_enable_out(pout[2]), .clk_correct_out(pout[1]),
    .power_down_out(pout[0]), .channel_up_out(cup),
    .init_state_out(ist), .hard_error_out(herr));
  msl_far_model far (.core_clk_in(clk), .send_in(fs), .msg_in(fm),
    .last_in(fl), .word_in(fw), .pause_in(fp), .pause_count_in(fc),
    .lane_rx_data_out(lrd), .lane_rx_ctrl_out(lrc), .lane_rx_msg_out(lrm),
    .lane_rx_last_out(lrl), .lane_rx_pause_out(lrp),
    .lane_rx_pause_count_out(lrpc));
  // free-running 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // inputs move 1 ns after the edge, never on it
  task step;
    begin
      @(posedge clk);
      #1;
      seed = lfsr(seed);
    end
  endtask
  // bounded waits keep a dead handshake from hanging the run
  task wait_msg;
    begin
      n = 0;
      while (mack !== 1'b1 && n < 20) begin
        step;
        n = n + 1;
      end
      check("msg ack", mack, 1'b1);
      check("ready at ack", rdy, 1'b0);
      mreq = 1'b0;
    end
  endtask
  task wait_rdy;
    begin
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
        step;
        n = n + 1;
      end
      check("ready back", rdy, 1'b1);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // monitor: lane and receive outputs one edge after their cause
  always @(posedge clk) begin
    if (acc_q)
      check("lane data", {ltc, ltd}, {2'h0, txd_q});
    else if (chk_idle)
      check("lane idle", {ltc, ltd}, {2'h3, {2{`MSL_CHAR_IDLE}}});
    if (chk_rx) begin
      check("rx kind", {rmv, rxv}, rk_q);
      if (rk_q == 2'h1)
        check("rx data", rxd, rd_q);
      if (rk_q == 2'h2)
        check("rx msg data", rmd, rd_q);
      check("rx last", {rml, rxl}, rl_q);
    end
    acc_q <= txv & rdy;
    txd_q <= txd;
    rk_q <= (lrc == 2'h0) ? {lrm, ~lrm} : 2'h0;
    rd_q <= lrd;
    rl_q <= {lrl & lrm, lrl & ~lrm};
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end
  initial begin
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    check("reset ctrl", ltc, 2'h3);
    check("ready down", rdy, 1'b0);
    for (i = 0; i < 16; i = i + 1) begin
      pin = seed[3:0];
      sbx = seed[6:4];
      step;
      check("pins", pout, pin);
    end
    lup = 1'b1;
    sbx = 3'h7;
    repeat (6) step;
    check("channel up", cup, 1'b1);
    check("init state", ist, 2'h3);
    chk_idle = 1'b1;
    chk_rx = 1'b1;
    // random traffic both ways; hold a word until it is taken
    for (i = 0; i < 60; i = i + 1) begin
      if (!txv || acc_q) begin
        txd = seed[15:0];
        txv = seed[16] | seed[17];
        txl = seed[18];
      end
      fs = seed[19];
      fm = seed[20] & seed[21];
      fl = seed[22];
      fw = seed[31:16];
      step;
    end
    {txv, fs, chk_idle} = 3'h0;
    step;
    ccr = 1'b1;
    repeat (6) step;
    check("comp stall", rdy, 1'b0);
    check("comp lane", {ltc, ltd}, {2'h3, {2{`MSL_CHAR_CC}}});
    ccr = 1'b0;
    wait_rdy;
    // every message length, words on the data port after the ack
    for (i = 0; i < 8; i = i + 1) begin
      mlen = i[2:0];
      mreq = 1'b1;
      wait_msg;
      for (w = 0; w <= i; w = w + 1) begin
        txd = seed[15:0];
        txv = 1'b1;
        step;
      end
      txv = 1'b0;
      wait_rdy;
    end
    // warning holds a message back until it clears
    ccw = 1'b1;
    repeat (4) step;
    {mreq, mlen} = 4'h8;
    repeat (8) begin
      step;
      check("ack in warning", mack, 1'b0);
    end
    ccw = 1'b0;
    wait_msg;
    txv = 1'b1;
    step;
    txv = 1'b0;
    wait_rdy;
    for (i = 0; i < 16; i = i + 1) begin
      pcnt = i[3:0];
      preq = 1'b1;
      n = 0;
      while (pack !== 1'b1 && n < 20) begin
        step;
        n = n + 1;
      end
      check("pause ack", pack, 1'b1);
      check("pause word", {ltc, ltd},
        ({2'h3, {2{`MSL_CHAR_PAUSE}}} & 18'h3fff0) | pcnt);
      preq = 1'b0;
      step;
    end
    // far-end pause lands mid-frame: frame finishes, then idles
    {txl, txv} = 2'h1;
    repeat (2) step;
    fc = seed[3:0];
    fp = 1'b1;
    step;
    fp = 1'b0;
    repeat (3) begin
      step;
      check("mid frame", acc_q, 1'b1);
    end
    txl = 1'b1;
    step;
    txl = 1'b0;
    n = 0;
    step;
    while (acc_q !== 1'b1 && n < 40) begin
      n = n + 1;
      step;
    end
    // the cycle that decides the pause is idle too, then count+1 more
    check("pause idles", n, {1'b0, fc} + 5'h2);
    txv = 1'b0;
    step;
    check("no error", herr, 1'b0);
    complete_run;
  end
endmodule
